// File: src/ucr_baud_gen.sv
// Purpose : baud tick generator, one tick every divisor+1 clocks
// Assumes : divisor is stable or changes apply at once to the count in progress
// Notes   : tick is a one-cycle pulse from a flip-flop
`timescale 1ns/100ps
module ucr_baud_gen
  import ucr_pkg::*;
#(
  parameter int DIV_W = 16
)
(
  input  wire logic             sys_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             clk_en_i,
  input  wire logic [DIV_W-1:0] divisor_i,
  output logic                  baud_tick_o
);

  logic [DIV_W-1:0] cnt_ff;
  logic             tick_ff;

  // ********************************************************************
  // counter: rate = clock / (divisor + 1)
  // ********************************************************************
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_ff  <= '0;
      tick_ff <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (cnt_ff >= divisor_i)
      begin
        cnt_ff  <= '0;
        tick_ff <= 1'b1;
      end
      else
      begin
        cnt_ff  <= cnt_ff + DIV_W'(1);
        tick_ff <= 1'b0;
      end
    end
  end

  assign baud_tick_o = tick_ff;

endmodule // ucr_baud_gen

// File: src/ucr_pkg.sv
// Purpose : shared constants and types for the serial port control/irq register bank
// Assumes : 16-bit registers, word index addressing on a simple register port
// Notes   : register indices follow the core's six-register map
package ucr_pkg;

  // ********************************************************************
  // register map (word index)
  // ********************************************************************
  localparam logic [2:0] UCR_IDX_RXDATA  = 3'h0;
  localparam logic [2:0] UCR_IDX_TXDATA  = 3'h1;
  localparam logic [2:0] UCR_IDX_STATUS  = 3'h2;
  localparam logic [2:0] UCR_IDX_CONTROL = 3'h3;
  localparam logic [2:0] UCR_IDX_DIVISOR = 3'h4;
  localparam logic [2:0] UCR_IDX_EOP     = 3'h5;

  // ********************************************************************
  // bit positions shared by status flags and control enables
  // ********************************************************************
  localparam int UCR_BIT_PE   = 0;
  localparam int UCR_BIT_FE   = 1;
  localparam int UCR_BIT_BRK  = 2;
  localparam int UCR_BIT_ROE  = 3;
  localparam int UCR_BIT_TOE  = 4;
  localparam int UCR_BIT_TMT  = 5;
  localparam int UCR_BIT_TRDY = 6;
  localparam int UCR_BIT_RRDY = 7;
  localparam int UCR_BIT_EXC  = 8;
  localparam int UCR_BIT_TBRK = 9;
  localparam int UCR_BIT_CLEAR_SEND_CHANGE_FLAG = 10;
  localparam int UCR_BIT_RTS  = 11;
  localparam int UCR_BIT_EOPF = 12;

  // ********************************************************************
  // reset values and masks
  // ********************************************************************
  localparam logic [15:0] UCR_CONTROL_RST = 16'h0000;
  localparam logic [15:0] UCR_EOP_RST     = 16'h0000;
  localparam logic [15:0] UCR_DIVISOR_RST = 16'h00d8;
  localparam logic [15:0] UCR_CTL_MASK    = 16'h1fff;
  // sticky flags cleared by a status write
  localparam logic [15:0] UCR_STICKY_MASK = 16'h141f;
  localparam logic [15:0] UCR_UNDEF_RD    = 16'h0000;
  // enables that pair with a status flag; bits 9 and 11 are line controls
  localparam logic [15:0] UCR_IRQ_MASK    = 16'h15ff;

  // register port request
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [2:0]  idx;
    logic [15:0] wdata;
  } ucr_req_t;

  // raw condition events from the shifter / receiver side
  typedef struct packed {
    logic pe;
    logic fe;
    logic break_seen_flag;
    logic roe;
    logic tx_overrun_flag;
    logic clear_send_change_flag;
    logic eop;
  } ucr_evt_t;

  // level states from the shifter / receiver side
  typedef struct packed {
    logic shifter_idle_flag;
    logic trdy;
    logic rrdy;
    logic cts;
  } ucr_lvl_t;

endpackage

// File: src/ucr_regs.sv
// Purpose : control, divisor and end-of-packet registers with irq output
// Assumes : status flags arrive as same-clock events and levels; cts pin is async
// Notes   : reads return data one cycle after the read strobe
`timescale 1ns/100ps

module ucr_regs
  import ucr_pkg::*;
#(
  parameter bit          HAS_FLOW_CTL = 1'b1,
  parameter bit          HAS_BAUD_SW  = 1'b1,
  parameter bit          HAS_EOP      = 1'b1,
  parameter int          DIV_W        = 16,
  parameter logic [15:0] DIV_FIXED    = UCR_DIVISOR_RST
)
(
  input  wire logic     sys_clk_i,
  input  wire logic     rst_n_i,
  input  wire logic     clk_en_i,
  input  wire ucr_req_t req_i,
  input  wire ucr_evt_t evt_i,
  input  wire ucr_lvl_t lvl_i,
  input  wire logic     cts_n_i,
  input  wire logic     tx_shift_i,
  input  wire logic     rx_char_valid_i,
  input  wire logic [7:0] rx_char_i,
  output logic [15:0]   rdata_o,
  output logic          irq_o,
  output logic          txd_o,
  output logic          rts_n_o,
  output logic          baud_tick_o
);

  logic [15:0] control_ff;
  logic [15:0] nxt_control;
  logic [15:0] divisor_ff;
  logic [15:0] eop_char_ff;
  logic [15:0] flags_ff;
  logic [15:0] nxt_flags;
  logic [15:0] status_view;
  logic [15:0] rdata_ff;
  logic        irq_ff;
  logic        txd_ff;
  logic        rts_n_ff;
  logic        cts_meta_ff;
  logic        cts_sync_ff;
  logic        cts_prev_ff;
  logic        cts_edge;
  logic        eop_hit;
  logic        wr_status;
  logic [15:0] irq_hits;

  function automatic logic is_wr(input ucr_req_t r, input logic [2:0] idx);
    is_wr = r.wr && (r.idx == idx);
  endfunction

  // ********************************************************************
  // cts synchroniser and change detect
  // ********************************************************************
  // reset level matches the idle pin, so no false change follows reset
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cts_meta_ff <= 1'b1;
      cts_sync_ff <= 1'b1;
      cts_prev_ff <= 1'b1;
    end
    else if (clk_en_i)
    begin
      cts_meta_ff <= cts_n_i;
      cts_sync_ff <= cts_meta_ff;
      cts_prev_ff <= cts_sync_ff;
    end
  end

  assign cts_edge = HAS_FLOW_CTL && (cts_sync_ff != cts_prev_ff);

  // ********************************************************************
  // control register
  // ********************************************************************
  always_comb
  begin
    nxt_control = control_ff;
    if (is_wr(req_i, UCR_IDX_CONTROL))
    begin
      nxt_control = req_i.wdata & UCR_CTL_MASK;
      if (!HAS_FLOW_CTL)
      begin
        nxt_control[UCR_BIT_RTS] = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      control_ff <= UCR_CONTROL_RST;
    end
    else if (clk_en_i)
    begin
      control_ff <= nxt_control;
    end
  end

  // ********************************************************************
  // divisor and end-of-packet registers
  // ********************************************************************
  // without the baud option the tick keeps running at the fixed rate
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      divisor_ff <= DIV_FIXED;
    end
    else if (clk_en_i && HAS_BAUD_SW && is_wr(req_i, UCR_IDX_DIVISOR))
    begin
      divisor_ff <= req_i.wdata;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      eop_char_ff <= UCR_EOP_RST;
    end
    else if (clk_en_i && HAS_EOP && is_wr(req_i, UCR_IDX_EOP))
    begin
      eop_char_ff <= req_i.wdata;
    end
  end

  // end of packet seen on a received character or a character sent
  assign eop_hit = HAS_EOP && ((rx_char_valid_i && rx_char_i == eop_char_ff[7:0])
                   || evt_i.eop);

  // ********************************************************************
  // sticky status flags; a new event wins over a same-cycle clear
  // ********************************************************************
  assign wr_status = is_wr(req_i, UCR_IDX_STATUS);

  always_comb
  begin
    nxt_flags = flags_ff;
    if (wr_status)
    begin
      nxt_flags = flags_ff & ~UCR_STICKY_MASK;
    end
    // events are applied after the clear so a same-cycle event is kept
    if (evt_i.pe)
    begin
      nxt_flags[UCR_BIT_PE] = 1'b1;
    end
    if (evt_i.fe)
    begin
      nxt_flags[UCR_BIT_FE] = 1'b1;
    end
    if (evt_i.break_seen_flag)
    begin
      nxt_flags[UCR_BIT_BRK] = 1'b1;
    end
    if (evt_i.roe)
    begin
      nxt_flags[UCR_BIT_ROE] = 1'b1;
    end
    if (evt_i.tx_overrun_flag)
    begin
      nxt_flags[UCR_BIT_TOE] = 1'b1;
    end
    if (evt_i.clear_send_change_flag || cts_edge)
    begin
      nxt_flags[UCR_BIT_CLEAR_SEND_CHANGE_FLAG] = HAS_FLOW_CTL;
    end
    if (eop_hit)
    begin
      nxt_flags[UCR_BIT_EOPF] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      flags_ff <= 16'h0000;
    end
    else if (clk_en_i)
    begin
      flags_ff <= nxt_flags;
    end
  end

  // status as seen by software and by the irq logic
  always_comb
  begin
    status_view                 = flags_ff & UCR_STICKY_MASK;
    status_view[UCR_BIT_EXC]    = |flags_ff[UCR_BIT_TOE:UCR_BIT_PE];
    status_view[UCR_BIT_TMT]    = lvl_i.shifter_idle_flag;
    status_view[UCR_BIT_TRDY]   = lvl_i.trdy;
    status_view[UCR_BIT_RRDY]   = lvl_i.rrdy;
    status_view[UCR_BIT_RTS]    = HAS_FLOW_CTL && !cts_sync_ff;
  end

  // ********************************************************************
  // read port: control reads never disturb state
  // ********************************************************************
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rdata_ff <= 16'h0000;
    end
    else if (clk_en_i && req_i.rd)
    begin
      unique case (req_i.idx)
        UCR_IDX_STATUS  : rdata_ff <= status_view;
        UCR_IDX_CONTROL : rdata_ff <= control_ff;
        UCR_IDX_DIVISOR : rdata_ff <= HAS_BAUD_SW ? divisor_ff : UCR_UNDEF_RD;
        UCR_IDX_EOP     : rdata_ff <= HAS_EOP ? eop_char_ff : UCR_UNDEF_RD;
        default         : rdata_ff <= UCR_UNDEF_RD;
      endcase
    end
  end

  // ********************************************************************
  // irq and pins
  // ********************************************************************
  // flag and enable pair bit for bit; rts and break bits have no flag partner
  always_comb
  begin
    irq_hits = status_view & control_ff & UCR_IRQ_MASK;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      irq_ff <= 1'b0;
    end
    else if (clk_en_i)
    begin
      irq_ff <= |irq_hits;
    end
  end

  // txd is re-registered, so break takes hold one cycle after the write
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      txd_ff   <= 1'b1;
      rts_n_ff <= 1'b1;
    end
    else if (clk_en_i)
    begin
      txd_ff   <= control_ff[UCR_BIT_TBRK] ? 1'b0 : tx_shift_i;
      rts_n_ff <= ~control_ff[UCR_BIT_RTS];
    end
  end

  ucr_baud_gen #(
    .DIV_W (DIV_W)
  ) u_baud (
    .sys_clk_i   (sys_clk_i),
    .rst_n_i     (rst_n_i),
    .clk_en_i    (clk_en_i),
    .divisor_i   (divisor_ff[DIV_W-1:0]),
    .baud_tick_o (baud_tick_o)
  );

  assign rdata_o = rdata_ff;
  assign irq_o   = irq_ff;
  assign txd_o   = txd_ff;
  assign rts_n_o = rts_n_ff;

endmodule // ucr_regs

// File: test/uart_control_irq_regs_bench.sv
// Purpose : self-checking bench for the control/irq register bank
// Assumes : default build options, all optional registers present
// Notes   : every access leaves one idle cycle behind it
`timescale 1ns/100ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module uart_control_irq_regs_bench
  import ucr_pkg::*;
;
  // ********
  // stimulus and checking
  // ********
  logic        sys_clk_i, rst_n_i = 1'b0, clk_en_i = 1'b1, cts_n_i = 1'b1;
  logic        rx_char_valid_i = 1'b0, line_act = 1'b0, tx_level, b;
  logic        irq_o, txd_o, rts_n_o, baud_tick_o;
  logic [7:0]  rx_char_i = 8'h00;
  logic [15:0] rdata_o, v, exp_q[$];
  ucr_req_t    req_i = '0;
  ucr_evt_t    evt_i = '0;
  ucr_lvl_t    lvl_i = '0;
  int          bad_count, checks_done, cyc, t0;
  int          st_b[7] = '{0, 1, 2, 3, 4, 10, 12};
  int          en_b[8] = '{0, 1, 2, 3, 4, 10, 12, 8};
  int          ev_k[8] = '{0, 1, 2, 3, 4, 5, 6, 4};

  ucr_line_model u_line (.sys_clk_i(sys_clk_i), .active_i(line_act), .tx_level_o(tx_level));
  ucr_regs dut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i), .req_i(req_i),
    .evt_i(evt_i), .lvl_i(lvl_i), .cts_n_i(cts_n_i), .tx_shift_i(tx_level),
    .rx_char_valid_i(rx_char_valid_i), .rx_char_i(rx_char_i), .rdata_o(rdata_o),
    .irq_o(irq_o), .txd_o(txd_o), .rts_n_o(rts_n_o), .baud_tick_o(baud_tick_o));

  // a read notes its expected word, a write sends it
  task automatic bus(input logic r, input logic [2:0] i, input logic [15:0] d);
    if (r)
      exp_q.push_back(d);
    req_i = '{r, !r, i, r ? 16'h0000 : d};
    @(posedge sys_clk_i) #1;
    req_i = '0;
    @(posedge sys_clk_i) #1;
  endtask

  task automatic next_tick();
    @(posedge sys_clk_i) #1;
    while (baud_tick_o !== 1'b1)
      @(posedge sys_clk_i) #1;
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge sys_clk_i)
    if (req_i.rd)
    begin
      #2;
      v = exp_q.pop_front();
      `CHK("rdata", v, rdata_o)
    end

  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      complete_run();
    end
  end

  initial
  begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  initial
  begin
    void'($urandom(32'h03a1));
    repeat (16) @(posedge sys_clk_i);
    #1 rst_n_i = 1'b1;
    `CHK("rts_rst", 1'b1, rts_n_o)
    bus(1, UCR_IDX_CONTROL, UCR_CONTROL_RST);
    bus(1, UCR_IDX_EOP, UCR_EOP_RST);
    repeat (4)
    begin
      v = 16'($urandom);
      bus(0, UCR_IDX_CONTROL, v);
      bus(1, UCR_IDX_CONTROL, v & UCR_CTL_MASK);
      bus(1, UCR_IDX_CONTROL, v & UCR_CTL_MASK);
    end
    line_act = 1'b1;
    bus(0, UCR_IDX_CONTROL, 16'h0200);
    repeat (6)
    begin
      `CHK("txd_brk", 1'b0, txd_o)
      @(posedge sys_clk_i) #1;
    end
    bus(0, UCR_IDX_CONTROL, 16'h0800);
    `CHK("rts_on", 1'b0, rts_n_o)
    b = txd_o;
    @(posedge sys_clk_i) #1;
    `CHK("txd_free", !b, txd_o)
    line_act = 1'b0;
    foreach (en_b[k])
    begin
      bus(0, UCR_IDX_CONTROL, 16'h0001 << en_b[k]);
      evt_i = ucr_evt_t'(7'h40 >> ev_k[k]);
      @(posedge sys_clk_i) #1;
      evt_i = '0;
      repeat (2) @(posedge sys_clk_i);
      #1 `CHK("irq_set", 1'b1, irq_o)
      v = (16'h0001 << st_b[ev_k[k]]) | (ev_k[k] < 5 ? 16'h0100 : 16'h0000);
      bus(1, UCR_IDX_STATUS, v);
      bus(0, UCR_IDX_STATUS, 16'h0000);
      `CHK("irq_ack", 1'b0, irq_o)
      bus(1, UCR_IDX_STATUS, 16'h0000);
    end
    bus(1, UCR_IDX_DIVISOR, UCR_DIVISOR_RST);
    bus(0, UCR_IDX_DIVISOR, 16'h0003);
    bus(1, UCR_IDX_DIVISOR, 16'h0003);
    next_tick();
    next_tick();
    t0 = cyc;
    next_tick();
    `CHK("tick_gap", 4, cyc - t0)
    v = 16'($urandom_range(255));
    bus(0, UCR_IDX_EOP, v);
    bus(1, UCR_IDX_EOP, v);
    bus(0, 3'h6, 16'hffff);
    bus(1, 3'h6, UCR_UNDEF_RD);
    bus(1, UCR_IDX_CONTROL, 16'h0100);
    complete_run();
  end
endmodule // uart_control_irq_regs_bench

// File: test/ucr_line_model.sv
// Purpose : far-end transmitter level feeding the break override
// Assumes : shares the bus clock
// Notes   : toggles every cycle while active so a forced low cannot hide
`timescale 1ns/100ps
module ucr_line_model
(
  input  wire logic sys_clk_i,
  input  wire logic active_i,
  output logic      tx_level_o
);
  // ********
  // transmitter level, idle line high
  // ********
  always_ff @(posedge sys_clk_i)
    tx_level_o <= active_i ? !tx_level_o : 1'b1;
endmodule // ucr_line_model

// File: test/ucr_regs_properties.sv
// Purpose : port checker for the control/irq register bank
// Assumes : clk_en_i held high by the bench
// Notes   : ctl_ff shadows the last control write seen at the port
`timescale 1ns/100ps
module ucr_regs_properties
  import ucr_pkg::*;
(
  input wire logic        sys_clk_i,
  input wire logic        rst_n_i,
  input wire ucr_req_t    req_i,
  input wire ucr_evt_t    evt_i,
  input wire logic [15:0] rdata_o,
  input wire logic        irq_o,
  input wire logic        txd_o,
  input wire logic        rts_n_o,
  input wire logic        baud_tick_o
);
  // ********
  // control shadow and properties
  // ********
  logic [15:0] ctl_ff;
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
    if (!rst_n_i)
      ctl_ff <= 16'h0000;
    else if (req_i.wr && req_i.idx == UCR_IDX_CONTROL)
      ctl_ff <= req_i.wdata & UCR_CTL_MASK;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // no writes at all, so enables cannot change and sticky flags cannot clear meanwhile
  sequence s_quiet; (!req_i.wr)[*3]; endsequence
  sequence s_pe_armed; evt_i.pe && ctl_ff[UCR_BIT_PE] && !req_i.wr; endsequence
  sequence s_toe_armed; evt_i.tx_overrun_flag && ctl_ff[UCR_BIT_EXC] && !req_i.wr; endsequence

  chk_rst_lines_idle: assert property ($rose(rst_n_i) |-> txd_o && rts_n_o && !irq_o)
    else $error("serial lines or irq not idle after reset");
  chk_irq_masked: assert property ($past(ctl_ff) == 16'h0000 |-> !irq_o)
    else $error("irq high with all enables clear");
  chk_ctl_readback: assert property (req_i.rd && req_i.idx == UCR_IDX_CONTROL |=>
    rdata_o == $past(ctl_ff)) else $error("control read mismatch");
  chk_break_forces_low: assert property ($past(ctl_ff[UCR_BIT_TBRK]) |-> !txd_o)
    else $error("txd not low during break");
  chk_rts_inverted: assert property (rts_n_o == !$past(ctl_ff[UCR_BIT_RTS]))
    else $error("rts pin does not follow control bit");
  chk_pe_irq_rises: assert property (s_pe_armed ##1 s_quiet |-> irq_o)
    else $error("enabled parity flag gave no irq");
  chk_exc_irq_rises: assert property (s_toe_armed ##1 s_quiet |-> irq_o)
    else $error("enabled exception gave no irq");
  chk_tick_single: assert property (baud_tick_o |=> !baud_tick_o)
    else $error("baud tick longer than one cycle");
endmodule // ucr_regs_properties

bind ucr_regs ucr_regs_properties u_props (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .req_i(req_i), .evt_i(evt_i),
  .rdata_o(rdata_o), .irq_o(irq_o), .txd_o(txd_o), .rts_n_o(rts_n_o),
  .baud_tick_o(baud_tick_o));
